// File: logic/trmc_codec.v
// Renewal confirmation builder and flow removal request parser/answerer.
// Assumes the peer keeps valid steady for a whole message and honours ready.
`timescale 1ns/10ps
`include "trmc_map.vh"
module trmc_codec (
  input wire clk_sys, // 250 MHz system clock
  input wire nrst, // Async reset, active low
  input wire cnf_start, // Pulse: build a renewal confirmation
  input wire [7:0] origin_node_ident, // Originator node ident
  input wire [7:0] tunnel_flow_ident, // Tunnel flow ident
  input wire [7:0] result_code, // Outcome of rebuild
  input wire [3:0] relay_count, // Relays n in rebuilt tunnel
  input wire [63:0] relay_node_ident, // Relay node idents, entry k at [8k+7:8k]
  input wire [63:0] relay_flow_ident, // Relay flow idents, entry k
  input wire bidir, // Flow is bidirectional
  input wire [71:0] inverse_flow_ident, // Inverse idents, endpoint first
  input wire [7:0] fail_node_ident, // Node that failed
  output wire cnf_busy, // Confirmation being sent
  input wire rx_valid, // Removal request octet valid
  input wire [7:0] rx_data, // Removal request octet
  input wire rx_last, // Last octet of request
  output wire rx_ready, // Parser can take an octet
  output reg rx_malformed_r, // Pulse: bad payload dropped
  output reg rm_done_r, // Pulse: relay flow to delete
  output reg [7:0] rm_flow_ident_r, // Relay flow ident to delete
  output reg tx_valid_r, // Outgoing octet valid
  output reg [7:0] tx_data_r, // Outgoing octet
  output reg tx_last_r, // Last octet of message
  input wire tx_ready // Peer takes outgoing octet
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CNF = 2'b01;
  localparam ST_RMC = 2'b10;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] idx_r; // Octet index within message
  reg [4:0] len_r; // Octet count minus one
  reg [7:0] code_r;
  reg [3:0] cnt_r;
  reg bidir_r;
  reg [63:0] rnode_r;
  reg [63:0] rflow_r;
  reg [71:0] inv_r;
  reg [7:0] o0_r;
  reg [7:0] o1_r;
  reg [7:0] fail_r;
  reg [2:0] rx_idx_r; // Received octet index, saturating at 4
  reg [7:0] oct_nxt;
  wire [7:0] rx_q [0:3];
  wire [3:0] rx_ld;
  // Handshake terms shared by both message paths; confirmation success flag and direction octet position
  wire tx_go = tx_valid_r & tx_ready;
  wire tx_end = tx_go & tx_last_r;
  wire ok = (code_r == `TRMC_RC_OK);
  wire [4:0] dir_pos = {cnt_r, 1'b0} + `TRMC_OFS_RELAY;
  // Chooser looks one octet ahead while an octet waits, so the
  // output register reloads with the next octet on the accepting edge
  wire [4:0] sel_idx = (tx_valid_r & ~tx_last_r) ? idx_r + 5'd1 : idx_r;
  wire [4:0] rel_off = sel_idx - `TRMC_OFS_RELAY;
  wire [4:0] inv_off = sel_idx - dir_pos - 5'd1;
  wire rx_take = rx_valid & rx_ready;
  assign cnf_busy = (state_r == ST_CNF);
  // Request intake closes while any answer is built or sent
  assign rx_ready = (state_r == ST_IDLE) & ~cnf_start;

  // Captures of the four removal request octets
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rx
      assign rx_ld[g] = rx_take & (rx_idx_r == g);
      trmc_rx_field u_fld (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(rx_ld[g]),
        .din(rx_data),
        .q_r(rx_q[g])
      );
    end
  endgenerate

  // Octet chooser for the message being sent
  always @* begin
    oct_nxt = 8'h00;
    if (state_r == ST_RMC) begin
      case (sel_idx[1:0])
        2'd0: oct_nxt = rx_q[0];
        2'd1: oct_nxt = rx_q[1];
        2'd2: oct_nxt = rx_q[2];
        default: oct_nxt = rx_q[3];
      endcase
    end else if (sel_idx == `TRMC_OFS_ORIG) begin
      oct_nxt = o0_r;
    end else if (sel_idx == `TRMC_OFS_FLOW) begin
      oct_nxt = o1_r;
    end else if (sel_idx == `TRMC_OFS_CODE) begin
      oct_nxt = code_r;
    end else if (sel_idx == `TRMC_OFS_CNT) begin
      oct_nxt = ok ? {4'h0, cnt_r} : 8'h00;
    end else if (!ok) begin
      oct_nxt = fail_r;
    end else if (sel_idx < dir_pos) begin
      oct_nxt = rel_off[0] ? rflow_r[rel_off[4:1]*8 +: 8] : rnode_r[rel_off[4:1]*8 +: 8];
    end else if (sel_idx == dir_pos) begin
      oct_nxt = bidir_r ? `TRMC_DIR_BI : `TRMC_DIR_UNI;
    end else begin
      oct_nxt = inv_r[inv_off[3:0]*8 +: 8];
    end
  end

  // Next state
  // A start pulse closes intake, so start and request never coincide
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cnf_start) begin
          state_nxt = ST_CNF;
        end else if (rx_take & rx_last & (rx_idx_r == 3'd3)) begin
          state_nxt = ST_RMC;
        end
      end
      ST_CNF, ST_RMC: begin
        if (tx_end) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Message sequencing and captures
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      idx_r <= 5'd0;
      len_r <= 5'd0;
      code_r <= 8'h00;
      cnt_r <= 4'h0;
      bidir_r <= 1'b0;
      rnode_r <= 64'h0;
      rflow_r <= 64'h0;
      inv_r <= 72'h0;
      o0_r <= 8'h00;
      o1_r <= 8'h00;
      fail_r <= 8'h00;
      rx_idx_r <= 3'd0;
      rx_malformed_r <= 1'b0;
      rm_done_r <= 1'b0;
      rm_flow_ident_r <= 8'h00;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_malformed_r <= 1'b0;
      rm_done_r <= 1'b0;
      if (state_r == ST_IDLE && cnf_start) begin
        o0_r <= origin_node_ident;
        o1_r <= tunnel_flow_ident;
        // Reserved codes never leave; sent as insufficient resources
        code_r <= (result_code >= `TRMC_RC_RSV) ? `TRMC_RC_SUB : result_code;
        // Counts above eight clamp; the relay buses hold eight entries
        cnt_r <= (relay_count > `TRMC_MAX_RELAY) ? `TRMC_MAX_RELAY : relay_count;
        bidir_r <= bidir;
        rnode_r <= relay_node_ident;
        rflow_r <= relay_flow_ident;
        inv_r <= inverse_flow_ident;
        fail_r <= fail_node_ident;
        idx_r <= 5'd0;
      end
      // Length: success 4+2n+1(+n+1), failure 8 octets
      // Failure carries the failing node at octets four to seven
      if (state_r == ST_CNF && idx_r == 5'd0 && !tx_valid_r) begin
        if (!ok) begin
          len_r <= {1'b0, `TRMC_OFS_FAIL};
        end else if (bidir_r) begin
          len_r <= dir_pos + {1'b0, cnt_r} + 5'd1;
        end else begin
          len_r <= dir_pos;
        end
        tx_valid_r <= 1'b1;
        tx_data_r <= oct_nxt;
        tx_last_r <= 1'b0;
      end
      if (state_r == ST_RMC && !tx_valid_r) begin
        len_r <= {1'b0, `TRMC_REM_LEN} - 5'd1;
        tx_valid_r <= 1'b1;
        tx_data_r <= oct_nxt;
        tx_last_r <= 1'b0;
      end
      // Advance one octet per accepted cycle
      if (tx_go) begin
        if (tx_last_r) begin
          tx_valid_r <= 1'b0;
          tx_last_r <= 1'b0;
          idx_r <= 5'd0;
        end else begin
          idx_r <= idx_r + 5'd1;
        end
      end
      // Last flag rises as the final octet loads, never while it waits
      if (tx_valid_r && (idx_r + (tx_go ? 5'd1 : 5'd0)) == len_r && !tx_end) begin
        tx_last_r <= 1'b1;
      end
      if (tx_go && !tx_last_r) begin
        tx_data_r <= oct_nxt;
      end
      // Removal request parse: exactly four octets
      // Over-long requests saturate the index and end as malformed
      if (rx_take) begin
        rx_idx_r <= rx_last ? 3'd0 : ((rx_idx_r == 3'd4) ? 3'd4 : rx_idx_r + 3'd1);
        if (rx_last && rx_idx_r == 3'd3) begin
          rm_done_r <= 1'b1;
          rm_flow_ident_r <= rx_data;
          idx_r <= 5'd0;
        end else if (rx_last) begin
          rx_malformed_r <= 1'b1;
        end
      end
    end
  end

endmodule // trmc_codec

// File: pkg/trmc_map.vh
// Constants for the tunnel renewal and flow removal message codec.
// Assumes payload octets arrive and leave one per valid cycle, lowest first.
// How it works
// - Renewal request answered with renewal confirmation payload
// - Octets 0,1: originator ident, tunnel flow
// - Octet 2 result: 00 ok, 01-03 failures
// - 04-06 reverse failures; 07-ff reserved, never sent
// - Octet 3 relay count, zero unless success
// - Relay pairs from octet 4, node then flow
// - Relays, direction, inverse idents only on success
// - Direction flag after relays: 01 bi, 00 uni
// - n+1 inverse idents follow, endpoint first
// - Inverse idents only when direction is 01
// - On failure, failing node ident at octets 4-7
// - Removal request: four octets, origin/flow/relay/flow
// - Relay answers removal request with confirmation
// - Removal confirmation: four octets, same layout
`ifndef TRMC_MAP_VH
`define TRMC_MAP_VH
`define TRMC_RC_OK 8'h00
`define TRMC_RC_RSV 8'h07
`define TRMC_DIR_UNI 8'h00
`define TRMC_DIR_BI 8'h01
`define TRMC_OFS_ORIG 4'h0
`define TRMC_OFS_FLOW 4'h1
`define TRMC_OFS_CODE 4'h2
`define TRMC_OFS_CNT 4'h3
`define TRMC_OFS_FAIL 4'h7
`define TRMC_REM_LEN 4'h4
`define TRMC_MAX_RELAY 4'h8
`define TRMC_IDX_W 4
`define TRMC_OFS_RELAY 5'd4
`define TRMC_RC_SUB 8'h03
`endif

// File: logic/trmc_rx_field.v
// Byte-wide capture register with load enable, reset to zero.
// Assumes one system clock and asynchronous active-low reset.
`timescale 1ns/10ps
module trmc_rx_field (
  input wire clk_sys, // System clock
  input wire nrst, // Async reset, active low
  input wire load, // Capture strobe
  input wire [7:0] din, // Incoming octet
  output reg [7:0] q_r // Held octet
);
  // Capture on strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_r <= 8'h00;
    end else if (load) begin
      q_r <= din;
    end
  end
endmodule // trmc_rx_field

// File: tb/trmc_codec_assertions.sv
// Checker for the codec's confirmation and removal streams.
// Assumes inputs held steady while a confirmation is in flight.
`timescale 1ns/10ps
module trmc_codec_assertions (
  input wire clk_sys, // Clock
  input wire nrst, // Reset
  input wire cnf_start, // Build
  input wire [7:0] origin_node_ident, // Origin
  input wire [7:0] fail_node_ident, // Failer
  input wire cnf_busy, // Busy
  input wire rx_valid, // Req valid
  input wire [7:0] rx_data, // Req octet
  input wire rx_last, // Req last
  input wire rx_ready, // Req ready
  input wire rx_malformed_r, // Bad req
  input wire rm_done_r, // Good req
  input wire [7:0] rm_flow_ident_r, // Flow
  input wire tx_valid_r, // Out valid
  input wire [7:0] tx_data_r, // Out octet
  input wire tx_last_r, // Out last
  input wire tx_ready // Out taken
);
  reg [4:0] idx_r;
  reg [7:0] code_r;
  reg [7:0] rxb_r;
  // Octet position, sent code, last request octet
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 5'd0;
      code_r <= 8'h00;
      rxb_r <= 8'h00;
    end else begin
      if (tx_valid_r && tx_ready) idx_r <= tx_last_r ? 5'd0 : idx_r + 5'd1;
      if (tx_valid_r && tx_ready && idx_r == 5'd2) code_r <= tx_data_r;
      if (rx_valid && rx_ready) rxb_r <= rx_data;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  tx_hold_a: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r) && $stable(tx_last_r))
    else $error("tx octet changed before taken");
  start_answer_a: assert property (cnf_start && !cnf_busy && !tx_valid_r |-> ##2 tx_valid_r && tx_data_r == $past(origin_node_ident, 2))
    else $error("confirmation start wrong");
  code_legal_a: assert property (cnf_busy && tx_valid_r && idx_r == 5'd2 |-> tx_data_r < 8'h07)
    else $error("reserved result code sent");
  fail_zero_a: assert property (cnf_busy && tx_valid_r && idx_r == 5'd3 && code_r != 8'h00 |-> tx_data_r == 8'h00)
    else $error("relay count not zero on failure");
  fail_node_a: assert property (cnf_busy && tx_valid_r && idx_r == 5'd7 && code_r != 8'h00 |-> tx_data_r == fail_node_ident && tx_last_r)
    else $error("failing node octet wrong");
  rx_block_a: assert property (cnf_busy |-> !rx_ready)
    else $error("request taken while sending");
  rx_answer_a: assert property (rx_valid && rx_ready && rx_last |-> ##[1:2] (rm_done_r || rx_malformed_r))
    else $error("request not judged");
  rm_flow_a: assert property (rm_done_r |-> rm_flow_ident_r == rxb_r && !rx_malformed_r)
    else $error("removal flow wrong");
  last_end_a: assert property (tx_valid_r && tx_last_r && tx_ready |=> !tx_valid_r)
    else $error("octet after last");
  cover property (cnf_busy && tx_last_r && tx_ready);
  cover property (rm_done_r);
  cover property (rx_malformed_r);
endmodule // trmc_codec_assertions
bind trmc_codec trmc_codec_assertions trmc_codec_assertions_i (.clk_sys(clk_sys), .nrst(nrst),
  .cnf_start(cnf_start), .origin_node_ident(origin_node_ident), .fail_node_ident(fail_node_ident),
  .cnf_busy(cnf_busy), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
  .rx_malformed_r(rx_malformed_r), .rm_done_r(rm_done_r), .rm_flow_ident_r(rm_flow_ident_r),
  .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_last_r(tx_last_r), .tx_ready(tx_ready));

// File: tb/trmc_peer.sv
// Peer node: sends removal requests and stalls the outgoing stream.
// Assumes the bench has seeded $urandom.
`timescale 1ns/10ps
module trmc_peer (
  input wire clk_sys, // Clock
  input wire rx_ready, // Codec takes octet
  output logic rx_valid = 1'b0, // Octet valid
  output logic [7:0] rx_data = 8'h00, // Octet
  output logic rx_last = 1'b0, // Last octet
  output logic tx_ready = 1'b0 // Take octet
);
  // Random stalls
  always @(negedge clk_sys) tx_ready <= ($urandom % 4) != 0;
  // Octets lowest first, each held until taken or for at most 50 cycles
  task automatic send(input logic [39:0] pkt, input int len, output bit ok);
    int t;
    bit rdy;
    ok = 1'b1;
    for (int i = 0; i < len; i++) begin
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_data = pkt[8*i +: 8];
      rx_last = (i == len - 1);
      t = 0;
      do begin
        #1 rdy = rx_ready;
        @(posedge clk_sys);
        t++;
      end while (!rdy && t < 50);
      if (!rdy) ok = 1'b0;
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_last = 1'b0;
  endtask
endmodule // trmc_peer

// File: tb/trmc_codec_bench.sv
// Bench for the codec: confirmations, removal requests, bad lengths.
// Assumes trmc_peer and the bound checker are compiled first.
`timescale 1ns/10ps
module trmc_codec_bench;
  logic clk_sys = 1'b0, nrst = 1'b0, cnf_start = 1'b0, bidir = 1'b0;
  logic [7:0] origin_node_ident = 8'h00, tunnel_flow_ident = 8'h00, result_code = 8'h00, fail_node_ident = 8'h00;
  logic [3:0] relay_count = 4'h0;
  logic [63:0] relay_node_ident = 64'h0, relay_flow_ident = 64'h0;
  logic [71:0] inverse_flow_ident = 72'h0;
  wire cnf_busy, rx_valid, rx_last, rx_ready, rx_malformed_r, rm_done_r, tx_valid_r, tx_last_r, tx_ready;
  wire [7:0] rx_data, rm_flow_ident_r, tx_data_r;
  int miscompares = 0, samples_checked = 0;
  logic [8:0] expq[$];
  bit ok;
  trmc_codec trmc_codec_i (.clk_sys(clk_sys), .nrst(nrst), .cnf_start(cnf_start),
    .origin_node_ident(origin_node_ident), .tunnel_flow_ident(tunnel_flow_ident), .result_code(result_code),
    .relay_count(relay_count), .relay_node_ident(relay_node_ident), .relay_flow_ident(relay_flow_ident),
    .bidir(bidir), .inverse_flow_ident(inverse_flow_ident), .fail_node_ident(fail_node_ident),
    .cnf_busy(cnf_busy), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .rx_malformed_r(rx_malformed_r), .rm_done_r(rm_done_r), .rm_flow_ident_r(rm_flow_ident_r),
    .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_last_r(tx_last_r), .tx_ready(tx_ready));
  trmc_peer trmc_peer_i (.clk_sys(clk_sys), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .tx_ready(tx_ready));
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Each octet taken against the oldest note
  always @(posedge clk_sys) if (tx_valid_r && tx_ready) begin
    if (expq.size() == 0) chk("tx_extra", {tx_last_r, tx_data_r}, 9'h1ff);
    else chk("tx_octet", {tx_last_r, tx_data_r}, expq.pop_front());
  end
  task automatic drain(input string nm);
    int t = 0;
    while ((expq.size() != 0 || tx_valid_r) && t < 200) begin
      @(negedge clk_sys);
      t++;
    end
    if (t == 200) begin
      miscompares++;
      conclude();
    end
    $display("test %s done", nm);
  endtask
  task automatic cnf(input logic [7:0] code, input logic [3:0] n, input logic bi);
    logic [7:0] rc;
    logic [3:0] nc;
    @(negedge clk_sys);
    {origin_node_ident, tunnel_flow_ident, fail_node_ident} = 24'($urandom);
    relay_node_ident = {$urandom, $urandom};
    relay_flow_ident = {$urandom, $urandom};
    inverse_flow_ident = {8'($urandom), $urandom, $urandom};
    result_code = code;
    relay_count = n;
    bidir = bi;
    cnf_start = 1'b1;
    rc = (code > 8'h06) ? 8'h03 : code;
    nc = (n > 4'h8) ? 4'h8 : n;
    expq.push_back({1'b0, origin_node_ident});
    expq.push_back({1'b0, tunnel_flow_ident});
    expq.push_back({1'b0, rc});
    expq.push_back({1'b0, (rc == 8'h00) ? {4'h0, nc} : 8'h00});
    if (rc == 8'h00) begin
      for (int k = 0; k < nc; k++) begin
        expq.push_back({1'b0, relay_node_ident[8*k +: 8]});
        expq.push_back({1'b0, relay_flow_ident[8*k +: 8]});
      end
      expq.push_back({1'b0, 7'h00, bi});
      for (int j = 0; j <= nc && bi; j++) expq.push_back({1'b0, inverse_flow_ident[8*j +: 8]});
    end else
      for (int k = 0; k < 4; k++) expq.push_back({1'b0, fail_node_ident});
    expq[expq.size() - 1][8] = 1'b1;
    @(negedge clk_sys);
    cnf_start = 1'b0;
    drain("confirm");
  endtask
  task automatic rem(input int len);
    logic [39:0] p;
    int t = 0;
    p = 40'({$urandom, $urandom});
    for (int k = 0; k < 4 && len == 4; k++) expq.push_back({k == 3, p[8*k +: 8]});
    trmc_peer_i.send(p, len, ok);
    chk("req_taken", {8'h00, ok}, 9'h001);
    while (!(rm_done_r || rx_malformed_r) && t < 4) begin
      @(negedge clk_sys);
      t++;
    end
    chk("rm_judge", {7'h00, rm_done_r, rx_malformed_r}, (len == 4) ? 9'h002 : 9'h001);
    if (len == 4) chk("rm_flow", {1'b0, rm_flow_ident_r}, {1'b0, p[31:24]});
    drain("removal");
  endtask
  initial begin
    void'($urandom(32'h7813ec22));
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    cnf(8'h00, 4'h0, 1'b1);
    cnf(8'h00, 4'h8, 1'b1);
    cnf(8'h00, 4'hb, 1'b0);
    for (int i = 0; i < 3; i++) cnf(8'h00, 4'($urandom % 8), 1'($urandom));
    for (int c = 1; c < 9; c++) cnf(8'(c), 4'($urandom), 1'b1);
    cnf(8'hff, 4'h2, 1'b0);
    rem(4);
    rem(3);
    rem(5);
    rem(4);
    conclude();
  end
endmodule // trmc_codec_bench
